// ---- design/cas_defs.svh ----
// Offsets, reset values, ranges, status codes and timing figures of the alignment search.
`ifndef CAS_DEFS_SVH
`define CAS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CAS_OFS_LOOP_COUNT     16'h0388
`define CAS_OFS_STATUS         16'h038a
`define CAS_OFS_DWELL          16'h038c
`define CAS_OFS_SWITCH_DLY     16'h038e
`define CAS_OFS_C2F_DLY        16'h0390

// ----------------------------------------------------------------------------
// Reset values and accepted ranges
// ----------------------------------------------------------------------------
`define CAS_RST_LOOP_COUNT     8'h05
`define CAS_RST_DWELL          16'h0002
`define CAS_RST_SWITCH_DLY     16'h0005
`define CAS_RST_C2F_DLY        16'h0032
`define CAS_MAX_LOOP_COUNT     8'h14
`define CAS_MIN_DWELL          16'h0001
`define CAS_MAX_DELAY          16'h00c8
`define CAS_INTER_LOOP_MS      16'h0064

// ----------------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------------
`define CAS_ST_DONE            8'h00
`define CAS_ST_ARMED           8'h01
`define CAS_ST_ACTIVE          8'h02
`define CAS_ST_ERROR           8'h0a
`define CAS_ST_IDLE            8'h0b

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CAS_MS_IN_NS           1000000
`define CAS_CLK_PERIOD_NS      50
`define CAS_CYCLES_PER_MS      (`CAS_MS_IN_NS / `CAS_CLK_PERIOD_NS)
`define CAS_NUM_VECTORS        6

`endif

// ---- design/cas_pkg.sv ----
// Types shared by the alignment search design.
package cas_pkg;

  typedef enum logic [2:0]
  {
    CAS_WAIT,
    CAS_DWELL,
    CAS_GAP,
    CAS_C2F,
    CAS_FINE,
    CAS_LOOPGAP,
    CAS_DIVIDE
  } cas_state_t;

  typedef logic [15:0] cas_word_t;

endpackage

// ---- design/cas_ms_timer.sv ----
// Millisecond countdown timer driven by a one-millisecond tick.
`timescale 1ns/1ps

module cas_ms_timer #(
  parameter int CYCLES_PER_MS = 20000
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] loadMs,
  output logic             expired
);

  localparam int TW = $clog2(CYCLES_PER_MS);

  logic [TW-1:0] tick_q;
  logic [15:0]   msLeft_q;
  logic          running_q;
  logic          tickNow;

  assign tickNow = (tick_q == TW'(CYCLES_PER_MS - 1));

  // ----------------------------------------------------------------------------
  // Tick and countdown
  // ----------------------------------------------------------------------------
  // The tick restarts with each interval so that a delay is always whole milliseconds.
  always_ff @(posedge core_clk)
  begin
    if (rst || start || tickNow || !running_q)
      tick_q <= '0;
    else
      tick_q <= tick_q + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      running_q <= 1'b0;
      msLeft_q  <= 16'h0000;
      expired   <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        running_q <= 1'b1;
        msLeft_q  <= loadMs;
      end
      else if (running_q && msLeft_q == 16'h0000)
      begin
        running_q <= 1'b0;
        expired   <= 1'b1;
      end
      else if (running_q && tickNow)
        msLeft_q <= msLeft_q - 16'h0001;
    end
  end

endmodule

// ---- design/commutation_alignment_search.sv ----
// Rotor alignment search sequencer with its parameter and status registers.
`timescale 1ns/1ps
`include "cas_defs.svh"

// Summary of operation
// - Loop count 0..20, default 5.
// - Phase offset is mean of loop angles.
// - Step current vectors, record position feedback.
// - Status 0 after successful search.
// - Status 1 armed; starts on next enable.
// - Status 2 while search runs.
// - Status 10 after a search error.
// - Status 11 when no search needed.
// - Reset status from feedback type: 11 or 1.
// - Status is read-only, eight bits.
// - Hold each coarse vector for dwell time.
// - Switch delay between successive vectors.
// - Coarse-to-fine delay 0..200 ms, default 50.
// - Wait coarse-to-fine delay before fine phase.
// - Each loop: coarse current, then fine velocity.
// - Inter-loop delay between loops, default 100.
module commutation_alignment_search #(
  parameter int CYCLES_PER_MS = `CAS_CYCLES_PER_MS,
  parameter int NUM_VECTORS   = `CAS_NUM_VECTORS
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  input  wire logic [15:0]       regAddr,
  input  wire cas_pkg::cas_word_t regWrData,
  output cas_pkg::cas_word_t     regRdData,
  input  wire logic              searchRequired,
  input  wire logic              driveEnable,
  input  wire logic              searchFault,
  input  wire cas_pkg::cas_word_t feedbackAngle,
  input  wire logic              fineDone,
  input  wire cas_pkg::cas_word_t fineAngle,
  output logic                   vectorApply,
  output logic [2:0]             vectorIndex,
  output logic                   fineActive,
  output cas_pkg::cas_word_t     coarseAngle,
  output cas_pkg::cas_word_t     phaseOffset,
  output logic                   phaseValid
);

  import cas_pkg::*;

  cas_state_t state_q;
  cas_state_t state_d;
  logic [7:0]  loops_q;
  logic [7:0]  status_q;
  cas_word_t   dwell_q;
  cas_word_t   switchDly_q;
  cas_word_t   c2fDly_q;
  logic [7:0]  loopNum_q;
  logic [20:0] sum_q;
  logic        enPrev_q;
  logic        strapDone_q;
  logic        tmrStart;
  cas_word_t   tmrLoad;
  logic        tmrExpired;

  // ----------------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------------
  wire wrLoops  = regWrEn && regAddr == `CAS_OFS_LOOP_COUNT &&
                  regWrData <= 16'(`CAS_MAX_LOOP_COUNT);
  wire wrDwell  = regWrEn && regAddr == `CAS_OFS_DWELL &&
                  regWrData >= `CAS_MIN_DWELL && regWrData <= `CAS_MAX_DELAY;
  wire wrSwitch = regWrEn && regAddr == `CAS_OFS_SWITCH_DLY &&
                  regWrData <= `CAS_MAX_DELAY;
  wire wrC2f    = regWrEn && regAddr == `CAS_OFS_C2F_DLY &&
                  regWrData <= `CAS_MAX_DELAY;
  wire enRise   = driveEnable && !enPrev_q;
  wire running  = state_q != CAS_WAIT;
  wire lastVec  = vectorIndex == 3'(NUM_VECTORS - 1);
  wire lastLoop = loopNum_q + 8'h01 >= loops_q;
  wire divMore  = sum_q >= 21'(loops_q);

  cas_word_t rdMux;
  assign rdMux = (regAddr == `CAS_OFS_LOOP_COUNT) ? {8'h00, loops_q}  :
                 (regAddr == `CAS_OFS_STATUS)     ? {8'h00, status_q} :
                 (regAddr == `CAS_OFS_DWELL)      ? dwell_q           :
                 (regAddr == `CAS_OFS_SWITCH_DLY) ? switchDly_q       :
                 (regAddr == `CAS_OFS_C2F_DLY)    ? c2fDly_q          : 16'h0000;

  // ----------------------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------------------
  // Writes are not accepted while a search runs so timing cannot change mid-sequence.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      loops_q     <= `CAS_RST_LOOP_COUNT;
      dwell_q     <= `CAS_RST_DWELL;
      switchDly_q <= `CAS_RST_SWITCH_DLY;
      c2fDly_q    <= `CAS_RST_C2F_DLY;
      regRdData   <= 16'h0000;
    end
    else
    begin
      if (wrLoops && !running)
        loops_q <= regWrData[7:0];
      if (wrDwell && !running)
        dwell_q <= regWrData;
      if (wrSwitch && !running)
        switchDly_q <= regWrData;
      if (wrC2f && !running)
        c2fDly_q <= regWrData;
      if (regRdEn)
        regRdData <= rdMux;
    end
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  always_comb
  begin
    state_d  = state_q;
    tmrStart = 1'b0;
    tmrLoad  = dwell_q;
    case (state_q)
      CAS_WAIT:
        if (enRise && status_q == `CAS_ST_ARMED)
        begin
          state_d  = (loops_q == 8'h00) ? CAS_DIVIDE : CAS_DWELL;
          tmrStart = loops_q != 8'h00;
        end
      CAS_DWELL:
        if (tmrExpired)
        begin
          state_d  = lastVec ? CAS_C2F : CAS_GAP;
          tmrStart = 1'b1;
          tmrLoad  = lastVec ? c2fDly_q : switchDly_q;
        end
      CAS_GAP:
        if (tmrExpired)
        begin
          state_d  = CAS_DWELL;
          tmrStart = 1'b1;
        end
      CAS_C2F:
        if (tmrExpired)
          state_d = CAS_FINE;
      CAS_FINE:
        if (fineDone)
        begin
          state_d  = lastLoop ? CAS_DIVIDE : CAS_LOOPGAP;
          tmrStart = !lastLoop;
          tmrLoad  = `CAS_INTER_LOOP_MS;
        end
      CAS_LOOPGAP:
        if (tmrExpired)
        begin
          state_d  = CAS_DWELL;
          tmrStart = 1'b1;
        end
      CAS_DIVIDE:
        if (!divMore || loops_q == 8'h00)
          state_d = CAS_WAIT;
      default:
        state_d = CAS_WAIT;
    endcase
    if (running && (searchFault || !driveEnable))
    begin
      state_d  = CAS_WAIT;
      tmrStart = 1'b0;
    end
  end

  cas_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst || (!running && !tmrStart)),
    .start    (tmrStart),
    .loadMs   (tmrLoad),
    .expired  (tmrExpired)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q     <= CAS_WAIT;
      status_q    <= `CAS_ST_IDLE;
      strapDone_q <= 1'b0;
      enPrev_q    <= 1'b0;
      vectorIndex <= 3'h0;
      loopNum_q   <= 8'h00;
      sum_q       <= 21'h00000;
      coarseAngle <= 16'h0000;
      phaseOffset <= 16'h0000;
      phaseValid  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      enPrev_q    <= driveEnable;
      strapDone_q <= 1'b1;
      // The feedback type is sampled one edge after reset release, never under reset.
      if (!strapDone_q)
        status_q <= searchRequired ? `CAS_ST_ARMED : `CAS_ST_IDLE;
      else if (running && (searchFault || !driveEnable))
        status_q <= `CAS_ST_ERROR;
      else if (state_q == CAS_WAIT && state_d != CAS_WAIT)
      begin
        status_q    <= `CAS_ST_ACTIVE;
        vectorIndex <= 3'h0;
        loopNum_q   <= 8'h00;
        sum_q       <= 21'h00000;
        phaseOffset <= 16'h0000;
        phaseValid  <= 1'b0;
      end
      else if (state_q == CAS_DIVIDE && state_d == CAS_WAIT)
      begin
        status_q   <= `CAS_ST_DONE;
        phaseValid <= 1'b1;
      end
      if (state_q == CAS_DWELL && tmrExpired)
      begin
        coarseAngle <= feedbackAngle;
        vectorIndex <= lastVec ? 3'h0 : vectorIndex + 3'h1;
      end
      if (state_q == CAS_FINE && fineDone)
      begin
        sum_q     <= sum_q + {5'h00, fineAngle};
        loopNum_q <= loopNum_q + 8'h01;
      end
      // Division by repeated subtraction: slow but tiny, and it runs once per search.
      if (state_q == CAS_DIVIDE && divMore && loops_q != 8'h00)
      begin
        sum_q       <= sum_q - 21'(loops_q);
        phaseOffset <= phaseOffset + 16'h0001;
      end
    end
  end

  assign vectorApply = state_q == CAS_DWELL;
  assign fineActive  = state_q == CAS_FINE;

endmodule

// ---- testbench/cas_motor_model.sv ----
// Motor and feedback stand-in: an angle per vector and a fine-stage result per loop.
`timescale 1ns/1ps
module cas_motor_model #(
  parameter int SLOW = 3
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       vectorApply,
  input  wire logic [2:0] vectorIndex,
  input  wire logic       fineActive,
  output cas_pkg::cas_word_t feedbackAngle,
  output logic            fineDone,
  output cas_pkg::cas_word_t fineAngle
);
  import cas_pkg::*;
  logic [3:0] waitQ;
  cas_word_t  loopQ;
  cas_word_t  angle;
  cas_word_t  pos;
  logic       fire;
  // Outside a valid moment the lines show the inverse, so a stale sample cannot pass.
  assign pos = 16'h0100 + {13'h0000, vectorIndex};
  assign feedbackAngle = vectorApply ? pos : ~pos;
  assign angle = 16'h000a + 16'h000b * (loopQ - 16'h0001);
  assign fineAngle = fineDone ? angle : ~angle;
  assign fire = fineActive && !fineDone && waitQ == 4'(SLOW);
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      waitQ <= 4'h0;
      loopQ <= 16'h0000;
      fineDone <= 1'b0;
    end
    else
    begin
      waitQ <= (fineActive && !fineDone && !fire) ? waitQ + 4'h1 : 4'h0;
      fineDone <= fire;
      loopQ <= loopQ + {15'h0000, fire};
    end
  end
endmodule

// ---- testbench/cas_monitor.sv ----
// Concurrent checks on the alignment search ports.
`timescale 1ns/1ps
module cas_monitor #(
  parameter int CYCLES_PER_MS = 4,
  parameter int NUM_VECTORS   = 6
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               regWrEn,
  input wire logic               regRdEn,
  input wire logic [15:0]        regAddr,
  input wire cas_pkg::cas_word_t regWrData,
  input wire cas_pkg::cas_word_t regRdData,
  input wire logic               searchRequired,
  input wire logic               driveEnable,
  input wire logic               searchFault,
  input wire cas_pkg::cas_word_t feedbackAngle,
  input wire logic               fineDone,
  input wire cas_pkg::cas_word_t fineAngle,
  input wire logic               vectorApply,
  input wire logic [2:0]         vectorIndex,
  input wire logic               fineActive,
  input wire cas_pkg::cas_word_t coarseAngle,
  input wire cas_pkg::cas_word_t phaseOffset,
  input wire logic               phaseValid
);
  import cas_pkg::*;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_LOOP_RANGE: assert property (regRdEn && regAddr == 16'h0388 |=> regRdData <= 16'h0014)
    else $error("loop count read out of range");
  AST_STATUS_CODE: assert property (regRdEn && regAddr == 16'h038a |=> regRdData inside {16'h0000, 16'h0001, 16'h0002, 16'h000a, 16'h000b})
    else $error("status read not a legal code");
  AST_DWELL_RANGE: assert property (regRdEn && regAddr == 16'h038c |=> regRdData inside {[16'h0001:16'h00c8]})
    else $error("dwell read out of range");
  AST_DELAY_RANGE: assert property (regRdEn && regAddr inside {16'h038e, 16'h0390} |=> regRdData <= 16'h00c8)
    else $error("delay read out of range");
  AST_RD_HOLD: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");
  AST_DWELL_MIN: assert property (disable iff (rst || searchFault) $rose(vectorApply) |-> vectorApply[*4])
    else $error("vector held shorter than one millisecond");
  AST_NO_OVERLAP: assert property (!(vectorApply && fineActive))
    else $error("coarse and fine stages overlap");
  AST_VEC_INDEX: assert property (vectorApply |-> vectorIndex < NUM_VECTORS)
    else $error("vector index beyond vector count");
  AST_FAULT_STOP: assert property (searchFault |-> ##[1:3] (!vectorApply && !fineActive))
    else $error("search kept running after a fault");
  AST_VALID_QUIET: assert property (phaseValid |-> !vectorApply && !fineActive)
    else $error("result flagged while search still running");
endmodule
bind commutation_alignment_search cas_monitor #(
  .CYCLES_PER_MS(CYCLES_PER_MS), .NUM_VECTORS(NUM_VECTORS)) cas_monitor_inst (
  .core_clk(core_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .searchRequired(searchRequired),
  .driveEnable(driveEnable), .searchFault(searchFault), .feedbackAngle(feedbackAngle),
  .fineDone(fineDone), .fineAngle(fineAngle), .vectorApply(vectorApply),
  .vectorIndex(vectorIndex), .fineActive(fineActive), .coarseAngle(coarseAngle),
  .phaseOffset(phaseOffset), .phaseValid(phaseValid));

// ---- testbench/commutation_alignment_search_tb_top.sv ----
// Self-checking bench for the alignment search sequencer.
`timescale 1ns/1ps
module commutation_alignment_search_tb_top;
  import cas_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       regWrEn = 1'b0;
  logic       regRdEn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  cas_word_t  regWrData = 16'h0000;
  logic       searchRequired = 1'b1;
  logic       driveEnable = 1'b0;
  logic       searchFault = 1'b0;
  cas_word_t  regRdData, feedbackAngle, fineAngle, coarseAngle, phaseOffset;
  logic       vectorApply, fineActive, fineDone, phaseValid;
  logic [2:0] vectorIndex;
  logic       vaQ = 1'b0;
  logic       faQ = 1'b0;
  int         num_errors = 0;
  int         n_checks = 0;
  int         nVec = 0;
  int         nFine = 0;
  always #25 core_clk = ~core_clk;
  // Four cycles a millisecond keeps the inter-loop wait at a few hundred cycles.
  commutation_alignment_search #(.CYCLES_PER_MS(4), .NUM_VECTORS(6))
    commutation_alignment_search_inst (
    .core_clk(core_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .searchRequired(searchRequired),
    .driveEnable(driveEnable), .searchFault(searchFault), .feedbackAngle(feedbackAngle),
    .fineDone(fineDone), .fineAngle(fineAngle), .vectorApply(vectorApply),
    .vectorIndex(vectorIndex), .fineActive(fineActive), .coarseAngle(coarseAngle),
    .phaseOffset(phaseOffset), .phaseValid(phaseValid));
  cas_motor_model #(.SLOW(3)) cas_motor_model_inst (
    .core_clk(core_clk), .rst(rst), .vectorApply(vectorApply), .vectorIndex(vectorIndex),
    .fineActive(fineActive), .feedbackAngle(feedbackAngle), .fineDone(fineDone),
    .fineAngle(fineAngle));
  always @(posedge core_clk)
  begin
    vaQ <= vectorApply;
    faQ <= fineActive;
    if (vectorApply === 1'b1 && vaQ === 1'b0)
      nVec++;
    if (fineActive === 1'b1 && faQ === 1'b0)
      nFine++;
  end
  task automatic chk(input cas_word_t act, input cas_word_t exp);
    n_checks++;
    if (act !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input cas_word_t exp);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  task automatic wrd(input logic [15:0] a, input cas_word_t d, input cas_word_t exp);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    rd(a, exp);
  endtask
  task automatic do_reset(input logic req);
    @(posedge core_clk);
    rst <= 1'b1;
    searchRequired <= req;
    driveEnable <= 1'b0;
    searchFault <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic enable_rise();
    @(posedge core_clk);
    driveEnable <= 1'b0;
    @(posedge core_clk);
    driveEnable <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    int i;
    do_reset(1'b1);
    rd(16'h0388, 16'h0005);
    rd(16'h038a, 16'h0001);
    rd(16'h038c, 16'h0002);
    rd(16'h038e, 16'h0005);
    rd(16'h0390, 16'h0032);
    rd(16'h0300, 16'h0000);
    wrd(16'h0388, 16'h0015, 16'h0005);
    wrd(16'h0388, 16'h0014, 16'h0014);
    wrd(16'h038a, 16'h0000, 16'h0001);
    wrd(16'h038c, 16'h0000, 16'h0002);
    wrd(16'h038c, 16'h00c8, 16'h00c8);
    wrd(16'h038e, 16'h00c9, 16'h0005);
    wrd(16'h0390, 16'h00c8, 16'h00c8);
    wrd(16'h0388, 16'h0002, 16'h0002);
    wrd(16'h038c, 16'h0001, 16'h0001);
    wrd(16'h038e, 16'h0000, 16'h0000);
    wrd(16'h038e, 16'h0001, 16'h0001);
    wrd(16'h0390, 16'h0000, 16'h0000);
    enable_rise();
    rd(16'h038a, 16'h0002);
    for (i = 0; i < 4000 && phaseValid !== 1'b1; i++)
      @(posedge core_clk);
    #1;
    chk({15'h0000, phaseValid}, 16'h0001);
    chk(phaseOffset, 16'h000f);
    chk(coarseAngle, 16'h0105);
    chk(16'(nVec), 16'h000c);
    chk(16'(nFine), 16'h0002);
    rd(16'h038a, 16'h0000);
    enable_rise();
    rd(16'h038a, 16'h0000);
    do_reset(1'b1);
    enable_rise();
    repeat (3) @(posedge core_clk);
    searchFault <= 1'b1;
    rd(16'h038a, 16'h000a);
    do_reset(1'b0);
    rd(16'h038a, 16'h000b);
    enable_rise();
    rd(16'h038a, 16'h000b);
    wrap_up();
  end
endmodule
